/* verilog/pwmsd_regs.svh */
// Register indices, field positions and reset values of the PWM clocking and shutdown block.
// Byte address of a register is four times its index.
`ifndef PWMSD_REGS_SVH
`define PWMSD_REGS_SVH
`define PWMSD_IDX_ENABLE    8'h00
`define PWMSD_IDX_POLARITY  8'h01
`define PWMSD_IDX_CLKSEL    8'h02
`define PWMSD_IDX_PRESCALE  8'h03
`define PWMSD_IDX_CONTROL   8'h04
`define PWMSD_IDX_SCALE_A   8'h08
`define PWMSD_IDX_SCALE_B   8'h09
`define PWMSD_IDX_SHUTDOWN  8'h0e
`define PWMSD_IDX_CNT_BASE  8'h20
`define PWMSD_IDX_PER_BASE  8'h28
`define PWMSD_IDX_DTY_BASE  8'h30
`define PWMSD_SD_FLAG       7
`define PWMSD_SD_IE         6
`define PWMSD_SD_RESTART    5
`define PWMSD_SD_LEVEL      4
`define PWMSD_SD_PIN        2
`define PWMSD_SD_ACTLVL     1
`define PWMSD_SD_ENA        0
`define PWMSD_CTL_FREEZE    0
`define PWMSD_CTL_IDLESTOP  1
`define PWMSD_PRE_A_LSB     0
`define PWMSD_PRE_B_LSB     4
`define PWMSD_PER_RESET     8'hff
`endif

/* verilog/pwmsd_pkg.sv */
// Types shared by the PWM clocking and shutdown block.
// Assumes nothing of its surroundings.
package pwmsd_pkg;
    typedef logic [7:0] pwmsd_byte_t;
    typedef logic [5:0] pwmsd_chmask_t;
endpackage

/* verilog/pwmsd_top.sv */
// Six-channel 8-bit PWM: prescaler, scaled clocks, channel timers, emergency shutdown.
// Assumes an AHB-Lite master on the bus clock; all inputs are synchronous except ch5_pin_in.
// Functional notes
// - Shutdown input change sets flag; write-one clears.
// - Interrupt request while flag and enable set.
// - Restart only when input deasserted; reads zero.
// - Clearing shutdown enable with input deasserted resumes after counter zero.
// - Active shutdown forces enabled outputs to level, except channel 5, which is then an undriven input.
// - Status bit shows channel 5 pin.
// - Active level bit selects shutdown polarity.
// - Shutdown enable makes pin input, arms feature.
// - Two prescaled clocks, ratios 1 to 128.
// - Freeze control stops prescaler in freeze.
// - Prescaler may stop when all channels disabled.
// - Scale down counter pulses at one, halved.
// - Scale zero counts as 256.
// - Scale write reloads its down counter.
// - Clock select picks prescaled or scaled clock.
// - Per-channel counter, period and duty registers.
// - Enable acts at once, waveform next clock.
// - Clock gate changes on edges; disabled holds.
// - Polarity sets starting level of each cycle.
// - Re-enabled counter continues from held value.
`include "pwmsd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pwmsd_top
    import pwmsd_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        freeze,
    input  wire logic        ch5_pin_in,
    output logic      [5:0]  pwm_out,
    output logic      [5:0]  pwm_oe,
    output logic             irq
);
    pwmsd_chmask_t channel_enable_ff, polarity_ff, channel_clock_select_ff;
    pwmsd_byte_t   prescale_ff, control_ff, scale_a_value_ff, scale_b_value_ff;
    logic          shutdown_change_flag_ff, shutdown_irq_enable_ff, shutdown_forced_level_ff;
    logic          ch5_active_level_ff, emergency_shutdown_enable_ff;
    pwmsd_byte_t   cnt_ff [6];
    pwmsd_byte_t   per_ff [6];
    pwmsd_byte_t   dty_ff [6];
    logic          wr_ff;
    pwmsd_byte_t   widx_ff;
    logic [31:0]   hrdata_ff;
    logic          hreadyout_ff;

    // Bus slave: no wait states, answer always OKAY
    wire  logic        addr_ok = hsel && htrans[1] && hready;
    wire  pwmsd_byte_t aidx    = haddr[9:2];
    wire  logic        wr      = wr_ff;
    wire  pwmsd_byte_t wd      = hwdata[7:0];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ff        <= 1'b0;
            widx_ff      <= 8'h00;
            hreadyout_ff <= 1'b0;
        end else begin
            wr_ff        <= addr_ok && hwrite && haddr[31:10] == 22'h000000;
            widx_ff      <= aidx;
            hreadyout_ff <= 1'b1;
        end
    end
    assign hreadyout = hreadyout_ff;
    assign hresp     = 1'b0;

    // Shutdown pin synchroniser; only the second stage is looked at
    logic pin_s1_ff, pin_s2_ff, sd_act_prev_ff;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
        end else begin
            pin_s1_ff <= ch5_pin_in;
            pin_s2_ff <= pin_s1_ff;
        end
    end
    wire logic sd_active = emergency_shutdown_enable_ff && (pin_s2_ff == ch5_active_level_ff);
    wire logic sd_change = emergency_shutdown_enable_ff && (sd_active != sd_act_prev_ff);
    wire logic sd_wr     = wr && widx_ff == `PWMSD_IDX_SHUTDOWN;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sd_act_prev_ff          <= 1'b0;
            shutdown_change_flag_ff <= 1'b0;
        end else begin
            sd_act_prev_ff <= sd_active;
            // New change wins over a simultaneous write-one clear
            if (sd_change)
                shutdown_change_flag_ff <= 1'b1;
            else if (sd_wr && wd[`PWMSD_SD_FLAG])
                shutdown_change_flag_ff <= 1'b0;
        end
    end

    // Release pending: channels stay forced until their counter next wraps or is written
    logic          rel_ff;
    pwmsd_chmask_t force_ff;
    pwmsd_chmask_t wrap;
    wire  logic    restart_req = sd_wr && wd[`PWMSD_SD_RESTART] && !sd_active;
    wire  logic    ena_drop    = sd_wr && !wd[`PWMSD_SD_ENA] && emergency_shutdown_enable_ff;
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            rel_ff <= 1'b0;
        else if (sd_active)
            rel_ff <= 1'b0;
        else if (restart_req || ena_drop)
            rel_ff <= 1'b1;
        else if (force_ff == 6'h00)
            rel_ff <= 1'b0;
    end

    // Control registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            channel_enable_ff            <= 6'h00;
            polarity_ff                  <= 6'h00;
            channel_clock_select_ff      <= 6'h00;
            prescale_ff                  <= 8'h00;
            control_ff                   <= 8'h00;
            scale_a_value_ff             <= 8'h00;
            scale_b_value_ff             <= 8'h00;
            shutdown_irq_enable_ff       <= 1'b0;
            shutdown_forced_level_ff     <= 1'b0;
            ch5_active_level_ff          <= 1'b0;
            emergency_shutdown_enable_ff <= 1'b0;
        end else if (wr) begin
            case (widx_ff)
                `PWMSD_IDX_ENABLE:   channel_enable_ff <= wd[5:0];
                `PWMSD_IDX_POLARITY: polarity_ff <= wd[5:0];
                `PWMSD_IDX_CLKSEL:   channel_clock_select_ff <= wd[5:0];
                `PWMSD_IDX_PRESCALE: prescale_ff <= wd & 8'h77;
                `PWMSD_IDX_CONTROL:  control_ff <= wd & 8'h03;
                `PWMSD_IDX_SCALE_A:  scale_a_value_ff <= wd;
                `PWMSD_IDX_SCALE_B:  scale_b_value_ff <= wd;
                `PWMSD_IDX_SHUTDOWN: begin
                    shutdown_irq_enable_ff       <= wd[`PWMSD_SD_IE];
                    shutdown_forced_level_ff     <= wd[`PWMSD_SD_LEVEL];
                    ch5_active_level_ff          <= wd[`PWMSD_SD_ACTLVL];
                    emergency_shutdown_enable_ff <= wd[`PWMSD_SD_ENA];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= shutdown_change_flag_ff && shutdown_irq_enable_ff && emergency_shutdown_enable_ff;
    end

    // Prescaler
    logic [6:0] presc_ff;
    wire  logic presc_run = !(control_ff[`PWMSD_CTL_FREEZE] && freeze) &&
                            !(control_ff[`PWMSD_CTL_IDLESTOP] && channel_enable_ff == 6'h00);
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            presc_ff <= 7'h00;
        else if (presc_run)
            presc_ff <= presc_ff + 7'h01;
    end
    wire logic [6:0] mask_a = 7'((8'h01 << prescale_ff[`PWMSD_PRE_A_LSB +: 3]) - 8'h01);
    wire logic [6:0] mask_b = 7'((8'h01 << prescale_ff[`PWMSD_PRE_B_LSB +: 3]) - 8'h01);
    wire logic       tick_a = presc_run && ((presc_ff & mask_a) == mask_a);
    wire logic       tick_b = presc_run && ((presc_ff & mask_b) == mask_b);

    // Scaled clocks: down counter then divide by two
    pwmsd_byte_t sca_ff, scb_ff;
    logic        tga_ff, tgb_ff;
    wire  logic  pulse_a = tick_a && sca_ff == 8'h01;
    wire  logic  pulse_b = tick_b && scb_ff == 8'h01;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sca_ff <= 8'h00;
            tga_ff <= 1'b0;
        end else begin
            if (wr && widx_ff == `PWMSD_IDX_SCALE_A)
                sca_ff <= wd;
            else if (pulse_a)
                sca_ff <= scale_a_value_ff;
            else if (tick_a)
                sca_ff <= sca_ff - 8'h01;
            if (pulse_a)
                tga_ff <= !tga_ff;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scb_ff <= 8'h00;
            tgb_ff <= 1'b0;
        end else begin
            if (wr && widx_ff == `PWMSD_IDX_SCALE_B)
                scb_ff <= wd;
            else if (pulse_b)
                scb_ff <= scale_b_value_ff;
            else if (tick_b)
                scb_ff <= scb_ff - 8'h01;
            if (pulse_b)
                tgb_ff <= !tgb_ff;
        end
    end
    wire logic tick_sa = pulse_a && tga_ff;
    wire logic tick_sb = pulse_b && tgb_ff;

    // Channel timers, left aligned
    pwmsd_chmask_t gate_ff, dm_ff;
    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_ch
            localparam bit USE_B = (i == 2) || (i == 3);
            wire logic src  = channel_clock_select_ff[i] ? (USE_B ? tick_sb : tick_sa)
                                                         : (USE_B ? tick_b : tick_a);
            // Enable also qualifies the step, so the closing tick of the gate never counts
            wire logic step = src && gate_ff[i] && channel_enable_ff[i];
            wire logic cwr  = wr && widx_ff == `PWMSD_IDX_CNT_BASE + 8'(i);
            wire pwmsd_byte_t nxt_cnt = wrap[i] ? 8'h00 : cnt_ff[i] + 8'h01;
            assign wrap[i] = cnt_ff[i] + 8'h01 >= per_ff[i];
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    gate_ff[i]  <= 1'b0;
                    cnt_ff[i]   <= 8'h00;
                    dm_ff[i]    <= 1'b0;
                    per_ff[i]   <= `PWMSD_PER_RESET;
                    dty_ff[i]   <= 8'h00;
                    force_ff[i] <= 1'b0;
                end else begin
                    // Gate only changes on a source edge; avoids a runt first count
                    if (src)
                        gate_ff[i] <= channel_enable_ff[i];
                    if (cwr) begin
                        cnt_ff[i] <= 8'h00;
                        dm_ff[i]  <= dty_ff[i] == 8'h00;
                    end else if (step) begin
                        cnt_ff[i] <= nxt_cnt;
                        dm_ff[i]  <= (nxt_cnt == dty_ff[i]) || (!wrap[i] && dm_ff[i]);
                    end
                    if (wr && widx_ff == `PWMSD_IDX_PER_BASE + 8'(i))
                        per_ff[i] <= wd;
                    if (wr && widx_ff == `PWMSD_IDX_DTY_BASE + 8'(i))
                        dty_ff[i] <= wd;
                    if (sd_active)
                        force_ff[i] <= 1'b1;
                    else if (rel_ff && (cwr || (step && wrap[i])))
                        force_ff[i] <= 1'b0;
                end
            end
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    pwm_out[i] <= 1'b0;
                    pwm_oe[i]  <= 1'b0;
                end else if (i == 5 && emergency_shutdown_enable_ff) begin
                    pwm_out[i] <= 1'b0;
                    pwm_oe[i]  <= 1'b0;
                end else if (channel_enable_ff[i]) begin
                    pwm_out[i] <= (sd_active || force_ff[i]) ? shutdown_forced_level_ff
                                : polarity_ff[i] ^ dm_ff[i];
                    pwm_oe[i]  <= 1'b1;
                end else begin
                    pwm_out[i] <= 1'b0;
                    pwm_oe[i]  <= 1'b0;
                end
            end
        end
    endgenerate

    // Read data registered in the address phase
    pwmsd_byte_t rd;
    always_comb begin
        rd = 8'h00;
        case (aidx)
            `PWMSD_IDX_ENABLE:   rd = {2'b00, channel_enable_ff};
            `PWMSD_IDX_POLARITY: rd = {2'b00, polarity_ff};
            `PWMSD_IDX_CLKSEL:   rd = {2'b00, channel_clock_select_ff};
            `PWMSD_IDX_PRESCALE: rd = prescale_ff;
            `PWMSD_IDX_CONTROL:  rd = control_ff;
            `PWMSD_IDX_SCALE_A:  rd = scale_a_value_ff;
            `PWMSD_IDX_SCALE_B:  rd = scale_b_value_ff;
            `PWMSD_IDX_SHUTDOWN: rd = {shutdown_change_flag_ff, shutdown_irq_enable_ff, 1'b0,
                                       shutdown_forced_level_ff, 1'b0, pin_s2_ff,
                                       ch5_active_level_ff, emergency_shutdown_enable_ff};
            default: begin
                if (aidx >= `PWMSD_IDX_CNT_BASE && aidx < `PWMSD_IDX_CNT_BASE + 8'h06)
                    rd = cnt_ff[3'(aidx - `PWMSD_IDX_CNT_BASE)];
                else if (aidx >= `PWMSD_IDX_PER_BASE && aidx < `PWMSD_IDX_PER_BASE + 8'h06)
                    rd = per_ff[3'(aidx - `PWMSD_IDX_PER_BASE)];
                else if (aidx >= `PWMSD_IDX_DTY_BASE && aidx < `PWMSD_IDX_DTY_BASE + 8'h06)
                    rd = dty_ff[3'(aidx - `PWMSD_IDX_DTY_BASE)];
            end
        endcase
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            hrdata_ff <= 32'h00000000;
        else if (addr_ok && !hwrite)
            hrdata_ff <= (haddr[31:10] == 22'h000000) ? {24'h000000, rd} : 32'h00000000;
    end
    assign hrdata = hrdata_ff;

    // Checks
    sequence sd_edge_s;
        sd_change;
    endsequence
    sequence flag_up_s;
        shutdown_change_flag_ff;
    endsequence
    property flag_on_change_p;
        @(posedge clock) disable iff (rst) sd_edge_s |=> flag_up_s;
    endproperty
    flag_on_change_a: assert property (flag_on_change_p) else $error("change flag not set");
    irq_gate_a: assert property (@(posedge clock) disable iff (rst)
        !shutdown_irq_enable_ff |=> !irq) else $error("irq raised while disabled");
    ena_gate_a: assert property (@(posedge clock) disable iff (rst)
        !emergency_shutdown_enable_ff |-> !sd_active && !sd_change) else $error("shutdown active while off");
    force_level_a: assert property (@(posedge clock) disable iff (rst)
        sd_active && channel_enable_ff[0] |=> pwm_out[0] == $past(shutdown_forced_level_ff))
        else $error("output not forced");
    restart_block_a: assert property (@(posedge clock) disable iff (rst)
        sd_active |=> !rel_ff) else $error("restart taken while active");
    scale_reload_a: assert property (@(posedge clock) disable iff (rst)
        wr && widx_ff == `PWMSD_IDX_SCALE_A |=> sca_ff == $past(wd)) else $error("scale A not reloaded");
    freeze_stop_a: assert property (@(posedge clock) disable iff (rst)
        control_ff[`PWMSD_CTL_FREEZE] && freeze |=> $stable(presc_ff)) else $error("prescaler ran in freeze");
    idle_stop_a: assert property (@(posedge clock) disable iff (rst)
        control_ff[`PWMSD_CTL_IDLESTOP] && channel_enable_ff == 6'h00 |=> $stable(presc_ff))
        else $error("prescaler ran while idle");
    halt_count_a: assert property (@(posedge clock) disable iff (rst)
        !gate_ff[0] && !(wr && widx_ff == `PWMSD_IDX_CNT_BASE) |=> $stable(cnt_ff[0]))
        else $error("disabled counter moved");
    pin_sync_a: assert property (@(posedge clock) disable iff (rst)
        pin_s2_ff == $past(ch5_pin_in, 2)) else $error("pin status not two-stage");
endmodule
`default_nettype wire

/* tb/pwmsd_load_model.sv */
// Far-side model: loads on the six outputs and the channel 5 shutdown source.
// Assumes the bench commands the shutdown source; only pwm_out[5] overrides it, while pwm_oe[5] is set.
`timescale 1ns/1ps
`default_nettype none
module pwmsd_load_model (
    input  wire logic       clock,
    input  wire logic [5:0] pwm_out,
    input  wire logic [5:0] pwm_oe,
    input  wire logic       src_en,
    input  wire logic       src_level,
    output logic            pin
);
    logic wander_ff = 1'b0;
    // No pull on the pin, so a released pin wanders instead of holding
    always @(posedge clock) wander_ff <= ~wander_ff;
    assign pin = pwm_oe[5] ? pwm_out[5] : (src_en ? src_level : wander_ff);
endmodule
`default_nettype wire

/* tb/test_pwmsd_top.sv */
// Self-checking bench for the PWM clocking and shutdown block.
// Assumes AHB-Lite with no wait states and a two-flop pin synchroniser.
`include "pwmsd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_pwmsd_top
    import pwmsd_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        freeze = 1'b0;
    logic        ch5_pin;
    logic [5:0]  pwm_out;
    logic [5:0]  pwm_oe;
    logic        irq;
    logic        src_en = 1'b1;
    logic        src_level = 1'b0;
    int          err_total = 0;
    int          check_count = 0;

    pwmsd_top dut_u (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .freeze(freeze), .ch5_pin_in(ch5_pin), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
    pwmsd_load_model load_u (.clock(clock), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .src_en(src_en),
        .src_level(src_level), .pin(ch5_pin));

    initial begin
        forever #5 clock = ~clock;
    end

    task automatic end_sim();
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic bus(input logic wr, input int idx, input pwmsd_byte_t wd, output pwmsd_byte_t rd);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= 32'(idx * 4);
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata[7:0];
    endtask

    task automatic wr(input int idx, input pwmsd_byte_t d);
        pwmsd_byte_t x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd(input int idx, output pwmsd_byte_t d);
        bus(1'b0, idx, 8'h00, d);
    endtask

    // High cycles of one output, sampled after each edge has settled
    task automatic measure(input int ch, input int n, output int hi);
        hi = 0;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (pwm_out[ch] === 1'b1)
                hi++;
        end
    endtask

    // Model: tick every 2^n cycles, or 2*scale ticks when scaled; high time d or p-d ticks
    task automatic wave(input int ch, input int n, input int p, input int d, input int pol,
                        input int sel, input int s);
        int t;
        int hi;
        t = (1 << n) * (sel ? 2 * (s == 0 ? 256 : s) : 1);
        // Other prescaler gets a different ratio so a wrong clock choice shows
        if (ch == 2 || ch == 3)
            wr(`PWMSD_IDX_PRESCALE, 8'((n << 4) | ((n + 1) & 7)));
        else
            wr(`PWMSD_IDX_PRESCALE, 8'((((n + 1) & 7) << 4) | n));
        wr(`PWMSD_IDX_SCALE_A, 8'(s));
        wr(`PWMSD_IDX_SCALE_B, 8'(s));
        wr(`PWMSD_IDX_CLKSEL, 8'(sel << ch));
        wr(`PWMSD_IDX_POLARITY, 8'(pol << ch));
        wr(`PWMSD_IDX_PER_BASE + ch, 8'(p));
        wr(`PWMSD_IDX_DTY_BASE + ch, 8'(d));
        wr(`PWMSD_IDX_CNT_BASE + ch, 8'h00);
        wr(`PWMSD_IDX_ENABLE, 8'(1 << ch));
        repeat (2 * p * t) @(posedge clock);
        measure(ch, 4 * p * t, hi);
        `CHK(hi, 4 * t * (pol ? d : p - d))
        wr(`PWMSD_IDX_ENABLE, 8'h00);
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        end_sim();
    end

    initial begin
        pwmsd_byte_t v;
        pwmsd_byte_t c1;
        pwmsd_byte_t c2;
        int hi;
        int p;
        void'($urandom(97289));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rd(`PWMSD_IDX_SHUTDOWN, v);
        `CHK(v, 8'h00)
        rd(`PWMSD_IDX_PER_BASE + 3, v);
        `CHK(v, 8'hff)
        wr(8'h7f, 8'h5a);
        rd(8'h7f, v);
        `CHK(v, 8'h00)
        `CHK(hresp, 1'b0)
        for (int i = 0; i < 6; i++) begin
            p = 2 + $urandom % 7;
            wave(i, $urandom % 4, p, 1 + $urandom % (p - 1), $urandom % 2, 0, 0);
        end
        wave(0, 0, 2, 1, 1, 1, 0);
        wave(3, 1, 3, 1, 0, 1, 3);
        // Disabled counter holds, then resumes from the held count
        wr(`PWMSD_IDX_PRESCALE, 8'h03);
        wr(`PWMSD_IDX_CLKSEL, 8'h00);
        wr(`PWMSD_IDX_PER_BASE + 1, 8'hff);
        wr(`PWMSD_IDX_CNT_BASE + 1, 8'h00);
        wr(`PWMSD_IDX_ENABLE, 8'h02);
        repeat (100) @(posedge clock);
        `CHK(pwm_oe[1], 1'b1)
        wr(`PWMSD_IDX_ENABLE, 8'h00);
        rd(`PWMSD_IDX_CNT_BASE + 1, c1);
        repeat (50) @(posedge clock);
        rd(`PWMSD_IDX_CNT_BASE + 1, c2);
        `CHK(c2, c1)
        wr(`PWMSD_IDX_ENABLE, 8'h02);
        repeat (40) @(posedge clock);
        rd(`PWMSD_IDX_CNT_BASE + 1, c2);
        `CHK(c2 > c1 && c2 < c1 + 8'h0a, 1'b1)
        wr(`PWMSD_IDX_CONTROL, 8'h01);
        freeze <= 1'b1;
        rd(`PWMSD_IDX_CNT_BASE + 1, c1);
        repeat (50) @(posedge clock);
        rd(`PWMSD_IDX_CNT_BASE + 1, c2);
        `CHK(c2, c1)
        freeze <= 1'b0;
        repeat (50) @(posedge clock);
        rd(`PWMSD_IDX_CNT_BASE + 1, c2);
        `CHK(c2 !== c1, 1'b1)
        // Idle stop must not stop the prescaler while a channel is enabled
        wr(`PWMSD_IDX_CONTROL, 8'h02);
        rd(`PWMSD_IDX_CNT_BASE + 1, c1);
        repeat (50) @(posedge clock);
        rd(`PWMSD_IDX_CNT_BASE + 1, c2);
        `CHK(c2 !== c1, 1'b1)
        wr(`PWMSD_IDX_ENABLE, 8'h00);
        repeat (20) @(posedge clock);
        `CHK(pwm_oe[1], 1'b0)
        // Shutdown: ch0 period 4 duty 2 high-first, ch1 left disabled
        wr(`PWMSD_IDX_CONTROL, 8'h00);
        wr(`PWMSD_IDX_PRESCALE, 8'h00);
        wr(`PWMSD_IDX_POLARITY, 8'h01);
        wr(`PWMSD_IDX_PER_BASE, 8'h04);
        wr(`PWMSD_IDX_DTY_BASE, 8'h02);
        wr(`PWMSD_IDX_ENABLE, 8'h01);
        wr(`PWMSD_IDX_SHUTDOWN, 8'h53);
        `CHK(pwm_oe[5], 1'b0)
        src_level <= 1'b1;
        repeat (6) @(posedge clock);
        measure(0, 16, hi);
        `CHK(hi, 16)
        `CHK(pwm_out[1], 1'b0)
        `CHK(irq, 1'b1)
        rd(`PWMSD_IDX_SHUTDOWN, v);
        `CHK(v, 8'hd7)
        wr(`PWMSD_IDX_SHUTDOWN, 8'hf3);
        rd(`PWMSD_IDX_SHUTDOWN, v);
        `CHK(v, 8'h57)
        `CHK(irq, 1'b0)
        measure(0, 16, hi);
        `CHK(hi, 16)
        wr(`PWMSD_IDX_SHUTDOWN, 8'h13);
        src_level <= 1'b0;
        repeat (6) @(posedge clock);
        `CHK(irq, 1'b0)
        rd(`PWMSD_IDX_SHUTDOWN, v);
        `CHK(v, 8'h93)
        measure(0, 16, hi);
        `CHK(hi, 16)
        wr(`PWMSD_IDX_SHUTDOWN, 8'hb3);
        repeat (8) @(posedge clock);
        measure(0, 16, hi);
        `CHK(hi, 8)
        // Channel 5 enabled while the pin is an input: it must stay undriven
        wr(`PWMSD_IDX_ENABLE, 8'h21);
        repeat (2) @(posedge clock);
        `CHK(pwm_oe[5], 1'b0)
        `CHK(pwm_oe[0], 1'b1)
        end_sim();
    end
endmodule
`default_nettype wire
